// >>> logic/hcm_cfg.svh
/*
  Constants of the host-side memory controller: register offsets, control
  field positions, reset values, bus answers and transfer size codes.
  Assumes it is included by its bare name from files that need it.
*/
`ifndef HCM_CFG_SVH
`define HCM_CFG_SVH

// ==========================================================
// Register offsets (byte addresses on the AXI4-Lite bus)
`define HCM_OFS_CTRL 8'h00
`define HCM_OFS_FLT_LIMIT 8'h04
`define HCM_OFS_STATUS 8'h08
`define HCM_OFS_RD_COUNT 8'h0C
`define HCM_OFS_WR_COUNT 8'h10
`define HCM_OFS_LAST_ADDR 8'h14
`define HCM_OFS_MEM_ADDR 8'h18
`define HCM_OFS_MEM_DATA 8'h1C

// ==========================================================
// Control register fields and reset values
`define HCM_CTRL_SPLIT 0
`define HCM_CTRL_BIG 1
`define HCM_CTRL_FLOAT 2
`define HCM_CTRL_WAIT_LSB 4
`define HCM_CTRL_WAIT_MSB 7
`define HCM_CTRL_RST 32'h0000_0010
`define HCM_FLT_RST 32'h0000_0400

// ==========================================================
// Bus answers, size codes, lane patterns
`define HCM_RESP_OKAY 2'h0
`define HCM_RESP_SLVERR 2'h2
`define HCM_SIZE_BYTE 2'h0
`define HCM_SIZE_HALF 2'h1
`define HCM_SIZE_WORD 2'h2
`define HCM_LANES_ALL 4'hF
`define HCM_LANES_LO 4'h3
`define HCM_LANES_HI 4'hC
`define HCM_WAIT_ZERO 4'h0

`endif

// >>> logic/hcm_pkg.sv
/*
  Types shared by the host-side memory controller.
  Assumes nothing of its surroundings.
*/
package hcm_pkg;
  // ==========================================================
  // Bus cycle sequencer states
  typedef enum logic [2:0]
  {
    HCM_IDLE = 3'b001,
    HCM_WAIT = 3'b010,
    HCM_DONE = 3'b100
  } hcm_state_e;

  typedef logic [31:0] hcm_word_t;
  typedef logic [3:0] hcm_lane_t;
  typedef logic [1:0] hcm_size_t;
endpackage

// >>> logic/hcm_mem.sv
/*
  Word memory with byte write enables behind the host controller.
  Port a serves the core's bus cycles, port b the software loader.
  Assumes a single clock; read data come out of a register.
*/
`timescale 1ns/100ps

module hcm_mem
#(
  parameter int DEPTH = 1024,
  parameter int AW = 10
)
(
  // Clock
  input wire logic clk,
  // Core port
  input wire logic [AW-1:0] a_addr,
  input wire logic a_we,
  input wire hcm_pkg::hcm_lane_t a_be,
  input wire hcm_pkg::hcm_word_t a_wdata,
  output hcm_pkg::hcm_word_t a_rdata,
  // Loader port
  input wire logic b_we,
  input wire logic [AW-1:0] b_addr,
  input wire hcm_pkg::hcm_word_t b_wdata
);
  import hcm_pkg::*;

  hcm_word_t mem [DEPTH];

  // ==========================================================
  // Storage; core writes come last so they win a same-word clash
  always_ff @(posedge clk)
  begin
    a_rdata <= mem[a_addr];
    if (b_we)
    begin
      mem[b_addr] <= b_wdata;
    end
    for (int i = 0; i < 4; i++)
    begin
      if (a_we && a_be[i])
      begin
        mem[a_addr][8*i +: 8] <= a_wdata[8*i +: 8];
      end
    end
  end
endmodule

// >>> logic/hcm_host.sv
/*
  Host-side memory controller for a 32-bit core's data bus: serves the
  core's bus cycles from a local memory over split or shared data lines,
  drives the core's bus configuration inputs, signals memory faults.
  Assumes core pins are synchronous to CLK and software uses AXI4-Lite.
*/
// Design decisions made here: the AXI4-Lite register port and the register offsets.
// Operation
// - Shared-line mode keeps the bus-split select low.
// - Split mode: shared data lines are neither driven nor read.
// - Active-low drive gate lets the host hold off core driving.
// - Test-float is held high when not used for test.
// - Memory fault is signalled at the end of the bus cycle.
// - Stall does not touch lane latches; hold stall until final part.
// - Lane-latch inputs are tied high; words assembled externally.
// - Word uses all lanes; halfword half chosen by address bit and endian.
// - Byte lane follows address bits, mirrored in big-endian mode.
// - Subword writes are replicated; memory writes only the selected byte lanes.
`timescale 1ns/100ps
`include "hcm_cfg.svh"

module hcm_host
#(
  parameter int DEPTH = 1024,
  parameter int AW = 10
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Core address class and request
  input wire logic MEM_REQ,
  input wire hcm_pkg::hcm_word_t ADDR,
  input wire logic WRITE_NOT_READ,
  input wire hcm_pkg::hcm_size_t XFER_SIZE,
  // Core data buses
  output hcm_pkg::hcm_word_t CORE_DIN,
  input wire hcm_pkg::hcm_word_t CORE_DOUT,
  input wire hcm_pkg::hcm_word_t DATA_IN,
  output hcm_pkg::hcm_word_t DATA_OUT,
  output logic DATA_OE,
  input wire logic CORE_DRIVE_INDICATOR_N,
  // Core bus configuration and control
  output logic BUS_SPLIT_SELECT,
  output logic EXTERNAL_DRIVE_GATE_N,
  output logic DATA_LANE_GATE,
  output logic ADDR_LANE_GATE,
  output logic TEST_FLOAT_ALL_N,
  output hcm_pkg::hcm_lane_t LANE_LATCH_OPEN,
  output logic ENDIAN_SELECT,
  output logic STALL_REQUEST_N,
  output logic MEM_FAULT,
  // AXI4-Lite write channels
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire hcm_pkg::hcm_word_t WDATA,
  input wire hcm_pkg::hcm_lane_t WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read channels
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output hcm_pkg::hcm_word_t RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  import hcm_pkg::*;

  // ==========================================================
  // Declarations
  hcm_state_e st_q, st_d;
  logic [3:0] wcnt_q, wcnt_d;
  hcm_word_t addr_q, addr_d, din_q, din_d, rd_cnt_q, rd_cnt_d, wr_cnt_q, wr_cnt_d;
  hcm_size_t size_q, size_d;
  logic wr_q, wr_d, flt_q, flt_d, gate_q, gate_d;
  hcm_word_t ctrl_q, ctrl_d, flim_q, flim_d, awaddr_q, awaddr_d;
  hcm_word_t wdata_q, wdata_d, rdata_q, rdata_d;
  hcm_lane_t wstrb_q, wstrb_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [AW-1:0] madr_q, madr_d;
  logic split, big, tfloat, start, do_wr, b_we;
  logic [AW-1:0] mem_addr;
  hcm_word_t mem_rdata, wmask;
  hcm_lane_t mem_be;

  assign split = ctrl_q[`HCM_CTRL_SPLIT];
  assign big = ctrl_q[`HCM_CTRL_BIG];
  assign tfloat = ctrl_q[`HCM_CTRL_FLOAT];
  // No new cycle is served while the core is floated for test
  assign start = (st_q == HCM_IDLE) && MEM_REQ && !tfloat;

  // ==========================================================
  // Lanes touched by a transfer of given size, address and endian
  function automatic hcm_lane_t lane_mask(hcm_size_t sz, logic [1:0] a, logic be);
    logic [1:0] idx;
    idx = be ? ~a : a;
    case (sz)
      `HCM_SIZE_WORD: lane_mask = `HCM_LANES_ALL;
      `HCM_SIZE_HALF: lane_mask = idx[1] ? `HCM_LANES_HI : `HCM_LANES_LO;
      default: lane_mask = hcm_lane_t'(1) << idx;
    endcase
  endfunction

  // ==========================================================
  // Local memory; the address comes straight from the pins at the start
  assign mem_addr = (st_q == HCM_IDLE) ? ADDR[AW+1:2] : addr_q[AW+1:2];
  assign mem_be = lane_mask(size_q, addr_q[1:0], big);

  hcm_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem
  (
    .clk(CLK),
    .a_addr(mem_addr),
    .a_we((st_q == HCM_DONE) && wr_q && !flt_q),
    .a_be(mem_be),
    .a_wdata(split ? CORE_DOUT : DATA_IN),
    .a_rdata(mem_rdata),
    .b_we(b_we),
    .b_addr(madr_q),
    .b_wdata(wdata_q)
  );

  // ==========================================================
  // Bus cycle sequencer: next values
  always_comb
  begin
    st_d = st_q;
    wcnt_d = wcnt_q;
    addr_d = addr_q;
    size_d = size_q;
    wr_d = wr_q;
    flt_d = flt_q;
    din_d = din_q;
    gate_d = gate_q;
    rd_cnt_d = rd_cnt_q;
    wr_cnt_d = wr_cnt_q;
    case (st_q)
      HCM_IDLE:
      begin
        flt_d = 1'b0;
        if (start)
        begin
          st_d = HCM_WAIT;
          addr_d = ADDR;
          size_d = XFER_SIZE;
          wr_d = WRITE_NOT_READ;
          wcnt_d = ctrl_q[`HCM_CTRL_WAIT_MSB:`HCM_CTRL_WAIT_LSB];
          gate_d = !WRITE_NOT_READ && !split;
        end
      end
      HCM_WAIT:
      begin
        if (wcnt_q == `HCM_WAIT_ZERO)
        begin
          st_d = HCM_DONE;
          din_d = wr_q ? din_q : mem_rdata;
          flt_d = {2'h0, addr_q[31:2]} >= flim_q;
        end
        else
        begin
          wcnt_d = wcnt_q - 4'h1;
        end
      end
      HCM_DONE:
      begin
        st_d = HCM_IDLE;
        gate_d = 1'b0;
        if (wr_q)
        begin
          wr_cnt_d = wr_cnt_q + 32'h1;
        end
        else
        begin
          rd_cnt_d = rd_cnt_q + 32'h1;
        end
      end
      default:
      begin
        st_d = HCM_IDLE;
        gate_d = 1'b0;
      end
    endcase
  end

  // Bus cycle sequencer: registers
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st_q <= HCM_IDLE;
      wcnt_q <= 4'h0;
      addr_q <= 32'h0;
      size_q <= 2'h0;
      wr_q <= 1'b0;
      flt_q <= 1'b0;
      din_q <= 32'h0;
      gate_q <= 1'b0;
      rd_cnt_q <= 32'h0;
      wr_cnt_q <= 32'h0;
    end
    else
    begin
      st_q <= st_d;
      wcnt_q <= wcnt_d;
      addr_q <= addr_d;
      size_q <= size_d;
      wr_q <= wr_d;
      flt_q <= flt_d;
      din_q <= din_d;
      gate_q <= gate_d;
      rd_cnt_q <= rd_cnt_d;
      wr_cnt_q <= wr_cnt_d;
    end
  end

  // ==========================================================
  // Core pins
  // stall from request until data
  assign STALL_REQUEST_N = !(start || (st_q == HCM_WAIT));
  assign MEM_FAULT = flt_q && (st_q == HCM_DONE);
  assign BUS_SPLIT_SELECT = split;
  assign ENDIAN_SELECT = big;
  assign TEST_FLOAT_ALL_N = !tfloat;
  // Legacy data gate and address gate stay enabling
  assign DATA_LANE_GATE = 1'b1;
  assign ADDR_LANE_GATE = 1'b1;
  assign LANE_LATCH_OPEN = `HCM_LANES_ALL;
  assign EXTERNAL_DRIVE_GATE_N = gate_q;
  assign CORE_DIN = din_q;
  assign DATA_OUT = din_q;
  // shared lines idle in split mode
  assign DATA_OE = (st_q == HCM_DONE) && !wr_q && !split && !tfloat && CORE_DRIVE_INDICATOR_N;

  // ==========================================================
  // AXI4-Lite slave: handshakes are combinational, answers registered
  assign AWREADY = !aw_have_q;
  assign WREADY = !w_have_q;
  assign ARREADY = !rvalid_q;
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;
  assign RVALID = rvalid_q;
  assign RRESP = rresp_q;
  assign RDATA = rdata_q;
  assign do_wr = aw_have_q && w_have_q && !bvalid_q;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  // Register file: next values
  always_comb
  begin
    aw_have_d = aw_have_q;
    awaddr_d = awaddr_q;
    w_have_d = w_have_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q && !BREADY;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !RREADY;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    flim_d = flim_q;
    madr_d = madr_q;
    b_we = 1'b0;
    if (AWVALID && !aw_have_q)
    begin
      aw_have_d = 1'b1;
      awaddr_d = {24'h0, AWADDR};
    end
    if (WVALID && !w_have_q)
    begin
      w_have_d = 1'b1;
      wdata_d = WDATA;
      wstrb_d = WSTRB;
    end
    if (do_wr)
    begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `HCM_RESP_OKAY;
      case (awaddr_q[7:0])
        `HCM_OFS_CTRL: ctrl_d = (ctrl_q & ~wmask) | (wdata_q & wmask);
        `HCM_OFS_FLT_LIMIT: flim_d = (flim_q & ~wmask) | (wdata_q & wmask);
        `HCM_OFS_MEM_ADDR: madr_d = wdata_q[AW-1:0];
        `HCM_OFS_MEM_DATA:
        begin
          b_we = 1'b1;
          madr_d = madr_q + AW'(1);
        end
        `HCM_OFS_STATUS, `HCM_OFS_RD_COUNT, `HCM_OFS_WR_COUNT, `HCM_OFS_LAST_ADDR: ;
        default: bresp_d = `HCM_RESP_SLVERR;
      endcase
    end
    if (ARVALID && !rvalid_q)
    begin
      rvalid_d = 1'b1;
      rresp_d = `HCM_RESP_OKAY;
      case (ARADDR)
        `HCM_OFS_CTRL: rdata_d = ctrl_q;
        `HCM_OFS_FLT_LIMIT: rdata_d = flim_q;
        `HCM_OFS_STATUS: rdata_d = {29'h0, wr_q, flt_q, st_q != HCM_IDLE};
        `HCM_OFS_RD_COUNT: rdata_d = rd_cnt_q;
        `HCM_OFS_WR_COUNT: rdata_d = wr_cnt_q;
        `HCM_OFS_LAST_ADDR: rdata_d = addr_q;
        `HCM_OFS_MEM_ADDR: rdata_d = 32'(madr_q);
        `HCM_OFS_MEM_DATA: rdata_d = 32'h0;
        default:
        begin
          rdata_d = 32'h0;
          rresp_d = `HCM_RESP_SLVERR;
        end
      endcase
    end
  end

  // Register file: registers
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      aw_have_q <= 1'b0;
      awaddr_q <= 32'h0;
      w_have_q <= 1'b0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0;
      ctrl_q <= `HCM_CTRL_RST;
      flim_q <= `HCM_FLT_RST;
      madr_q <= '0;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      awaddr_q <= awaddr_d;
      w_have_q <= w_have_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      flim_q <= flim_d;
      madr_q <= madr_d;
    end
  end

  // ==========================================================
  // Checks on the pins this controller owes the core and on the memory byte lane enables
  split_low_a: assert property (@(posedge CLK) disable iff (!NRST)
    !ctrl_q[`HCM_CTRL_SPLIT] |-> !BUS_SPLIT_SELECT)
    else $error("split select high in shared-line mode");
  lines_float_a: assert property (@(posedge CLK) disable iff (!NRST)
    BUS_SPLIT_SELECT |-> !DATA_OE)
    else $error("shared lines driven in split mode");
  gate_first_a: assert property (@(posedge CLK) disable iff (!NRST)
    $rose(DATA_OE) |-> EXTERNAL_DRIVE_GATE_N && $past(EXTERNAL_DRIVE_GATE_N))
    else $error("host drives lines without holding core off first");
  float_high_a: assert property (@(posedge CLK) disable iff (!NRST)
    !tfloat |-> TEST_FLOAT_ALL_N)
    else $error("test float pulled low while unused");
  fault_end_a: assert property (@(posedge CLK) disable iff (!NRST)
    MEM_FAULT |-> STALL_REQUEST_N ##1 !MEM_FAULT)
    else $error("fault not confined to cycle end");
  stall_hold_a: assert property (@(posedge CLK) disable iff (!NRST)
    start ##1 (st_q == HCM_WAIT) |-> !STALL_REQUEST_N until (st_q == HCM_DONE))
    else $error("stall released before data presented");
  stall_bound_a: assert property (@(posedge CLK) disable iff (!NRST)
    start |-> ##[1:17] (st_q == HCM_DONE))
    else $error("bus cycle not completed in time");
  lanes_open_a: assert property (@(posedge CLK) disable iff (!NRST)
    LANE_LATCH_OPEN == `HCM_LANES_ALL)
    else $error("lane latches not all open");
  half_lane_a: assert property (@(posedge CLK) disable iff (!NRST)
    (st_q == HCM_DONE) && (size_q == `HCM_SIZE_HALF) |->
    (mem_be == ((addr_q[1] ^ big) ? `HCM_LANES_HI : `HCM_LANES_LO)))
    else $error("halfword lanes wrong");
  byte_lane_a: assert property (@(posedge CLK) disable iff (!NRST)
    (st_q == HCM_DONE) && (size_q == `HCM_SIZE_BYTE) |->
    $onehot(mem_be) && mem_be[big ? ~addr_q[1:0] : addr_q[1:0]])
    else $error("byte lane wrong");
endmodule

// >>> sim/hcm_core_model.sv
/*
  Behavioural model of the 32-bit core's data side, facing the host.
  Assumes the host answers on its stall line and changes on rising edges.
*/
`timescale 1ns/100ps

module hcm_core_model
(
  // Clock
  input wire logic clk,
  // Address class
  output logic mem_req,
  output hcm_pkg::hcm_word_t addr,
  output logic write_not_read,
  output hcm_pkg::hcm_size_t xfer_size,
  // Data buses
  input wire hcm_pkg::hcm_word_t core_din,
  output hcm_pkg::hcm_word_t core_dout,
  output hcm_pkg::hcm_word_t shared_lvl,
  input wire hcm_pkg::hcm_word_t host_out,
  input wire logic host_oe,
  output logic drive_n,
  // Configuration and answers from the host
  input wire logic split,
  input wire logic big,
  input wire logic gate_n,
  input wire logic data_gate,
  input wire logic float_n,
  input wire hcm_pkg::hcm_lane_t lane_open,
  input wire logic stall_n,
  input wire logic fault
);
  import hcm_pkg::*;
  hcm_word_t store_q = 32'h0000_0000;
  hcm_word_t last_q = 32'h0000_0000;
  hcm_word_t latch_q = 32'h0000_0000;
  int clashes = 0;

  // ==========================================================
  // Shared data lines
  // drive on gated writes
  assign drive_n = !(mem_req && write_not_read && !split && !gate_n && data_gate && float_n);
  // Nobody driving: pattern flips, so a stale value never passes
  assign shared_lvl = host_oe ? host_out : (!drive_n ? store_q : ~last_q);
  // store data only in split mode
  assign core_dout = split ? store_q : 32'h0000_0000;

  initial
  begin
    mem_req = 1'b0;
    addr = 32'h0000_0000;
    write_not_read = 1'b0;
    xfer_size = 2'h0;
  end

  // Level memory for the floating pattern
  always @(posedge clk)
  begin
    last_q <= shared_lvl;
  end

  // Both ends driving at once is a bus clash
  always @(negedge clk)
  begin
    if (host_oe === 1'b1 && drive_n === 1'b0) clashes++;
  end

  task automatic access(input logic wr, input hcm_size_t sz, input hcm_word_t a,
    input hcm_word_t wd, output hcm_word_t bus, output hcm_word_t val,
    output logic flt, output int stalls);
    logic done;
    int lane;
    done = 1'b0;
    stalls = 0;
    flt = 1'b0;
    @(posedge clk);
    mem_req <= 1'b1;
    addr <= a;
    write_not_read <= wr;
    xfer_size <= sz;
    if (wr) store_q <= (sz == 2'h0) ? {4{wd[7:0]}} : (sz == 2'h1) ? {2{wd[15:0]}} : wd;
    while (!done)
    begin
      @(negedge clk);
      done = (stall_n === 1'b1);
      for (int k = 0; k < 4; k++)
      begin
        if (done && lane_open[k]) latch_q[8*k +: 8] = split ? core_din[8*k +: 8] : shared_lvl[8*k +: 8];
      end
      // fault taken at cycle end, kept with its access
      flt = done && (fault === 1'b1);
      stalls += done ? 0 : 1;
      @(posedge clk);
    end
    mem_req <= 1'b0;
    bus = latch_q;
    lane = (sz == 2'h0) ? (big ? 3 - a[1:0] : a[1:0]) : ((a[1] ^ big) ? 2 : 0);
    val = (sz == 2'h0) ? {24'h0, bus[8*lane +: 8]} : (sz == 2'h1) ? {16'h0, bus[8*lane +: 16]} : bus;
  endtask
endmodule

// >>> sim/test_hcm_host.sv
/*
  Self-checking bench of the host memory controller: AXI4-Lite tasks, core model.
  Assumes the design's default memory depth and a 20 MHz clock.
*/
`timescale 1ns/100ps
`include "hcm_cfg.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end

module test_hcm_host;
  import hcm_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic mem_req, wnr, split_sel, gate_n, data_gate, addr_gate, float_n, endian, stall_n, fault;
  logic drive_n, data_oe, awready, wready, bvalid, arready, rvalid, f;
  hcm_word_t addr, core_din, core_dout, shared_lvl, data_out, rdata, last_bus, v, b, w;
  hcm_size_t xfer_size;
  hcm_lane_t lane_open;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  hcm_word_t wdata = 32'h0000_0000;
  hcm_lane_t wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [1:0] bresp, rresp;
  int n_errors = 0, n_checks = 0, cycles = 0, last_stalls;

  hcm_host DUT
  (
    .CLK(clk), .NRST(nrst), .MEM_REQ(mem_req), .ADDR(addr), .WRITE_NOT_READ(wnr),
    .XFER_SIZE(xfer_size), .CORE_DIN(core_din), .CORE_DOUT(core_dout), .DATA_IN(shared_lvl),
    .DATA_OUT(data_out), .DATA_OE(data_oe), .CORE_DRIVE_INDICATOR_N(drive_n),
    .BUS_SPLIT_SELECT(split_sel), .EXTERNAL_DRIVE_GATE_N(gate_n), .DATA_LANE_GATE(data_gate),
    .ADDR_LANE_GATE(addr_gate), .TEST_FLOAT_ALL_N(float_n), .LANE_LATCH_OPEN(lane_open),
    .ENDIAN_SELECT(endian), .STALL_REQUEST_N(stall_n), .MEM_FAULT(fault),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready)
  );

  hcm_core_model core
  (
    .clk(clk), .mem_req(mem_req), .addr(addr), .write_not_read(wnr), .xfer_size(xfer_size),
    .core_din(core_din), .core_dout(core_dout), .shared_lvl(shared_lvl), .host_out(data_out),
    .host_oe(data_oe), .drive_n(drive_n), .split(split_sel), .big(endian), .gate_n(gate_n),
    .data_gate(data_gate), .float_n(float_n), .lane_open(lane_open), .stall_n(stall_n),
    .fault(fault)
  );

  // ==========================================================
  // Clock and hang guard
  always #25 clk = ~clk;

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_errors++;
      stop_test();
    end
  end

  // ==========================================================
  // Bus tasks; handshakes judged at the falling edge, acted on at the rising one
  task automatic axi_wr(input logic [7:0] a, input hcm_word_t d, input logic [1:0] er);
    logic aw_ok, w_ok, b_ok;
    b_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok)
    begin
      @(negedge clk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = (bvalid === 1'b1);
      if (b_ok) `CHK(bresp, er)
      @(posedge clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input hcm_word_t ed, input logic [1:0] er);
    logic ar_ok, r_ok;
    r_ok = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_ok)
    begin
      @(negedge clk);
      ar_ok = arvalid && arready;
      r_ok = (rvalid === 1'b1);
      if (r_ok) `CHK(rdata, ed)
      if (r_ok) `CHK(rresp, er)
      @(posedge clk);
      if (ar_ok) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  // Core cycle; refused or faulted reads carry no value worth comparing
  task automatic acc(input logic wr, input hcm_size_t sz, input hcm_word_t a,
    input hcm_word_t d, input hcm_word_t ev, input logic ef);
    core.access(wr, sz, a, d, last_bus, v, f, last_stalls);
    `CHK(f, ef)
    if (!wr && !ef && last_stalls > 0) `CHK(v, ev)
  endtask

  task automatic stop_test();
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    `CHK(split_sel, 1'b0)
    `CHK(lane_open, `HCM_LANES_ALL)
    `CHK({data_gate, addr_gate, float_n, gate_n}, 4'hE)
    axi_rd(`HCM_OFS_CTRL, `HCM_CTRL_RST, `HCM_RESP_OKAY);
    axi_rd(`HCM_OFS_FLT_LIMIT, `HCM_FLT_RST, `HCM_RESP_OKAY);
    for (int i = 2; i < 8; i++) axi_rd(8'(4 * i), 32'h0, `HCM_RESP_OKAY);
    axi_rd(8'h40, 32'h0, `HCM_RESP_SLVERR);
    axi_wr(8'h40, 32'h1, `HCM_RESP_SLVERR);
    acc(1'b1, `HCM_SIZE_WORD, 32'h0, 32'h0BAD_F00D, 32'h0, 1'b0);
    // Stall covers the request cycle plus one more than the wait count
    `CHK(last_stalls, 3)
    // Each mode and byte order over fresh words
    for (int m = 0; m < 4; m++)
    begin
      b = 32'h100 + 32'(m * 16);
      w = m[1] ? 32'h1011_1213 : 32'h1312_1110;
      axi_wr(`HCM_OFS_CTRL, 32'(m), `HCM_RESP_OKAY);
      `CHK({endian, split_sel}, 2'(m))
      for (int i = 0; i < 4; i++) acc(1'b1, `HCM_SIZE_BYTE, b + 32'(i), 32'h10 + 32'(i), 32'h0, 1'b0);
      acc(1'b0, `HCM_SIZE_WORD, b, 32'h0, w, 1'b0);
      `CHK(last_stalls, 2)
      for (int i = 0; i < 4; i++)
      begin
        acc(1'b0, `HCM_SIZE_BYTE, b + 32'(i), 32'h0, 32'h10 + 32'(i), 1'b0);
        `CHK(last_bus, w)
      end
      acc(1'b1, `HCM_SIZE_HALF, b + 32'h4, 32'h1234, 32'h0, 1'b0);
      acc(1'b1, `HCM_SIZE_HALF, b + 32'h6, 32'h5678, 32'h0, 1'b0);
      acc(1'b0, `HCM_SIZE_WORD, b + 32'h4, 32'h0, m[1] ? 32'h1234_5678 : 32'h5678_1234, 1'b0);
      acc(1'b0, `HCM_SIZE_HALF, b + 32'h6, 32'h0, 32'h5678, 1'b0);
    end
    axi_wr(`HCM_OFS_CTRL, 32'h31, `HCM_RESP_OKAY);
    acc(1'b0, `HCM_SIZE_WORD, 32'h134, 32'h0, 32'h1234_5678, 1'b0);
    `CHK(last_stalls, 5)
    axi_wr(`HCM_OFS_CTRL, 32'h01, `HCM_RESP_OKAY);
    acc(1'b1, `HCM_SIZE_WORD, 32'h40, 32'hCAFE_0001, 32'h0, 1'b0);
    axi_wr(`HCM_OFS_FLT_LIMIT, 32'h10, `HCM_RESP_OKAY);
    acc(1'b1, `HCM_SIZE_WORD, 32'h40, 32'hDEAD_0000, 32'h0, 1'b1);
    acc(1'b0, `HCM_SIZE_WORD, 32'h44, 32'h0, 32'h0, 1'b1);
    acc(1'b0, `HCM_SIZE_WORD, 32'h0, 32'h0, 32'h0BAD_F00D, 1'b0);
    axi_wr(`HCM_OFS_FLT_LIMIT, 32'h400, `HCM_RESP_OKAY);
    acc(1'b0, `HCM_SIZE_WORD, 32'h40, 32'h0, 32'hCAFE_0001, 1'b0);
    axi_wr(`HCM_OFS_CTRL, 32'h05, `HCM_RESP_OKAY);
    `CHK(float_n, 1'b0)
    acc(1'b0, `HCM_SIZE_WORD, 32'h0, 32'h0, 32'h0, 1'b0);
    `CHK(last_stalls, 0)
    axi_wr(`HCM_OFS_CTRL, 32'h01, `HCM_RESP_OKAY);
    `CHK(float_n, 1'b1)
    axi_wr(`HCM_OFS_MEM_ADDR, 32'h20, `HCM_RESP_OKAY);
    axi_wr(`HCM_OFS_MEM_DATA, 32'h1111_2222, `HCM_RESP_OKAY);
    axi_wr(`HCM_OFS_MEM_DATA, 32'h3333_4444, `HCM_RESP_OKAY);
    axi_rd(`HCM_OFS_MEM_DATA, 32'h0, `HCM_RESP_OKAY);
    axi_rd(`HCM_OFS_MEM_ADDR, 32'h22, `HCM_RESP_OKAY);
    acc(1'b0, `HCM_SIZE_WORD, 32'h80, 32'h0, 32'h1111_2222, 1'b0);
    acc(1'b0, `HCM_SIZE_WORD, 32'h84, 32'h0, 32'h3333_4444, 1'b0);
    // Served cycles only; the floated request never started one
    axi_rd(`HCM_OFS_WR_COUNT, 32'h1B, `HCM_RESP_OKAY);
    axi_rd(`HCM_OFS_RD_COUNT, 32'h22, `HCM_RESP_OKAY);
    axi_rd(`HCM_OFS_LAST_ADDR, 32'h84, `HCM_RESP_OKAY);
    axi_rd(`HCM_OFS_STATUS, 32'h0, `HCM_RESP_OKAY);
    `CHK(core.clashes, 0)
    stop_test();
  end
endmodule
